// File: shared/srpd_consts.svh
// Numeric constants of the refresh and power-down command issuer.
// Assumes one system clock that also feeds the memory clock pin.
`ifndef SRPD_CONSTS_SVH
`define SRPD_CONSTS_SVH

// Clock rate in MHz (100 ns period)
`define SRPD_CLK_MHZ          10
// Refresh period in ms and rows to cover in it
`define SRPD_REF_PERIOD_MS    64
`define SRPD_REF_ROWS         4096
// Default timings in ns, plain values to be set per part
`define SRPD_TRC_NS           70
`define SRPD_TRP_NS           20
`define SRPD_TXSR_NS          80
`define SRPD_TPDE_NS          10
// CAS latency, 2 or 3 clocks
`define SRPD_CAS_LAT          2
`define SRPD_CAS_LAT_MIN      2
`define SRPD_CAS_LAT_MAX      3
// Command codes on {ras_n, cas_n, we_n}
`define SRPD_CMD_NOP          3'h7
`define SRPD_CMD_BST          3'h6
`define SRPD_CMD_AREF         3'h1
// Level of idle control pins
`define SRPD_DQM_OFF          2'h0

`endif

// File: shared/srpd_pkg.sv
// Types shared by the refresh and power-down command issuer.
// Assumes srpd_consts.svh supplies all numbers.
package srpd_pkg;

	typedef enum logic [1:0] {
		SRPD_OP_NOP,
		SRPD_OP_BST,
		SRPD_OP_REF
	} srpd_op_t;

	typedef struct packed {
		srpd_op_t   op;
		logic [1:0] dqm;
	} srpd_req_t;

	typedef struct packed {
		logic       clk_en;
		logic       cke;
		logic       cs_n;
		logic [2:0] rcw;
		logic [1:0] dqm;
	} srpd_pins_t;

	typedef enum logic [2:0] {
		SRPD_IDLE,
		SRPD_BURST,
		SRPD_SELF,
		SRPD_CLK_RUN,
		SRPD_PD
	} srpd_state_t;

	typedef struct packed {
		srpd_state_t fsm;
		srpd_pins_t  pins;
		logic [15:0] timer;
		logic [15:0] refi;
		logic [12:0] cnt;
		logic        to_self;
		logic        pend;
	} srpd_st_t;

endpackage

// File: verilog/srpd_buf.sv
// Two-entry request buffer with valid and ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/100ps
module srpd_buf
	import srpd_pkg::*;
#(
	parameter int W     = 4,
	parameter int DEPTH = 2
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    rdy;
	} srpd_buf_st_t;

	srpd_buf_st_t st;
	srpd_buf_st_t next_st;
	logic         push;
	logic         pop;

	assign in_ready  = st.rdy;
	assign out_valid = (st.cnt != '0);
	assign out_data  = st.mem[st.rp];

	always_comb begin
		next_st = st;
		push    = in_valid && st.rdy;
		pop     = out_valid && out_ready;
		if (push) begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
		end
		if (pop) begin
			next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
		end
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
		// Ready is registered so the port comes from a flop
		next_st.rdy = (next_st.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st     <= '0;
			st.rdy <= 1'b1;
		end else begin
			st <= next_st;
		end
	end
endmodule

// File: verilog/srpd_ctrl.sv
// Host-side issuer of refresh, self-refresh, power-down and burst stop
// commands for a four-bank single-data-rate synchronous DRAM.
// Assumes the memory clock is this clock gated by sd_clk_en outside.
// Functional notes
// - Idle and wait cycles carry a selected no-operation command.
// - Auto refresh is RAS and CAS low, WE high, CKE high.
// - Issue 4096 auto refreshes per refresh period.
// - Auto refresh only with banks idle and CKE high the cycle before.
// - After auto refresh only NOPs until cycle and precharge times pass.
// - Self refresh entry is the refresh code with CKE going low.
// - In self refresh only CKE matters; hold it low throughout.
// - Leave self refresh by restarting the clock, then raising CKE.
// - Only NOP or deselect until self-refresh exit time has passed.
// - Full refresh burst just before and after self refresh.
// - Never stay in power-down beyond the refresh period.
// - Raise CKE only together with a NOP or deselect.
// - Next command no sooner than one cycle after power-down exit.
// - CAS latency is 2 or 3 clocks.
`timescale 1ns/100ps
`include "srpd_consts.svh"
module srpd_ctrl
	import srpd_pkg::*;
#(
	parameter int TRC_NS     = `SRPD_TRC_NS,
	parameter int TRP_NS     = `SRPD_TRP_NS,
	parameter int TXSR_NS    = `SRPD_TXSR_NS,
	parameter int TPDE_NS    = `SRPD_TPDE_NS,
	parameter int CAS_LAT    = `SRPD_CAS_LAT,
	parameter int REF_ROWS   = `SRPD_REF_ROWS,
	parameter int PERIOD_MS  = `SRPD_REF_PERIOD_MS,
	parameter int BURST_REFS = `SRPD_REF_ROWS
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire srpd_req_t   req,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        pd_req,
	input  wire logic        sr_req,
	output logic             sd_clk_en,
	output logic             sd_cke,
	output logic             sd_cs_n,
	output logic             sd_ras_n,
	output logic             sd_cas_n,
	output logic             sd_we_n,
	output logic [11:0]      sd_addr,
	output logic [1:0]       sd_ba,
	output logic [1:0]       sd_dqm,
	output logic             self_active,
	output logic             pd_active,
	output logic             refresh_due
);
	localparam int RC_RAW   = (TRC_NS * `SRPD_CLK_MHZ + 999) / 1000;
	localparam int RP_RAW   = (TRP_NS * `SRPD_CLK_MHZ + 999) / 1000;
	localparam int XSR_RAW  = (TXSR_NS * `SRPD_CLK_MHZ + 999) / 1000;
	localparam int PDE_RAW  = (TPDE_NS * `SRPD_CLK_MHZ + 999) / 1000;
	localparam int RC_CYC   = (RC_RAW < 1) ? 1 : RC_RAW;
	localparam int RP_CYC   = (RP_RAW < 1) ? 1 : RP_RAW;
	localparam int GAP_CYC  = (RC_CYC > RP_CYC) ? RC_CYC : RP_CYC;
	localparam int XSR_CYC  = (XSR_RAW < 1) ? 1 : XSR_RAW;
	localparam int PDE_CYC  = (PDE_RAW < 1) ? 1 : PDE_RAW;
	// Longest interval rounds down so refreshes are never late
	localparam int REFI_RAW = PERIOD_MS * 1000 * `SRPD_CLK_MHZ / REF_ROWS;
	localparam int REFI_CYC = (REFI_RAW < 1) ? 1 : REFI_RAW;

	srpd_st_t  st;
	srpd_st_t  next_st;
	srpd_req_t head;
	logic      head_valid;
	logic      head_ready;

	srpd_buf #(
		.W     ($bits(srpd_req_t)),
		.DEPTH (2)
	) u_buf (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_data   (req),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.out_data  (head),
		.out_valid (head_valid),
		.out_ready (head_ready)
	);

	assign sd_clk_en   = st.pins.clk_en;
	assign sd_cke      = st.pins.cke;
	assign sd_cs_n     = st.pins.cs_n;
	assign sd_ras_n    = st.pins.rcw[2];
	assign sd_cas_n    = st.pins.rcw[1];
	assign sd_we_n     = st.pins.rcw[0];
	assign sd_dqm      = st.pins.dqm;
	// Address and bank are don't care for every command issued here
	assign sd_addr     = '0;
	assign sd_ba       = '0;
	assign self_active = (st.fsm == SRPD_SELF);
	assign pd_active   = (st.fsm == SRPD_PD);
	assign refresh_due = st.pend;

	// Queue drains only when the command slot is free; this stalls users
	assign head_ready = (st.fsm == SRPD_IDLE) && (st.timer == '0)
		&& !sr_req && !st.pend;

	always_comb begin
		next_st          = st;
		next_st.pins.cs_n = 1'b0;
		next_st.pins.rcw  = `SRPD_CMD_NOP;
		next_st.pins.dqm  = `SRPD_DQM_OFF;
		if (st.timer != '0) begin
			next_st.timer = st.timer - 16'h0001;
		end
		// Interval tick; outside self refresh a tick in the cycle of a clear still counts
		if (st.refi == '0) begin
			next_st.refi = 16'(REFI_CYC - 1);
		end else begin
			next_st.refi = st.refi - 16'h0001;
		end
		unique case (st.fsm)
			SRPD_IDLE: begin
				if (st.timer != '0) begin
					next_st.fsm = SRPD_IDLE;
				end else if (sr_req) begin
					next_st.fsm     = SRPD_BURST;
					next_st.cnt     = 13'(BURST_REFS);
					next_st.to_self = 1'b1;
				end else if (st.pend) begin
					next_st.pins.rcw = `SRPD_CMD_AREF;
					next_st.pend     = 1'b0;
					next_st.timer    = 16'(GAP_CYC - 1);
				end else if (head_valid) begin
					next_st.pins.dqm = head.dqm;
					if (head.op == SRPD_OP_BST) begin
						next_st.pins.rcw = `SRPD_CMD_BST;
						next_st.timer    = 16'(CAS_LAT - 1);
					end else if (head.op == SRPD_OP_REF) begin
						next_st.pins.rcw = `SRPD_CMD_AREF;
						next_st.timer    = 16'(GAP_CYC - 1);
					end
				end else if (pd_req) begin
					next_st.fsm      = SRPD_PD;
					// Only dropped with nothing in flight, never mid burst
					next_st.pins.cke = 1'b0;
				end
			end
			SRPD_BURST: begin
				if (st.timer == '0) begin
					if (st.cnt == '0) begin
						if (st.to_self) begin
							next_st.fsm      = SRPD_SELF;
							next_st.pins.rcw = `SRPD_CMD_AREF;
							next_st.pins.cke = 1'b0;
						end else begin
							next_st.fsm = SRPD_IDLE;
						end
					end else begin
						next_st.pins.rcw = `SRPD_CMD_AREF;
						next_st.cnt      = st.cnt - 13'h0001;
						next_st.pend     = 1'b0;
						next_st.timer    = 16'(GAP_CYC - 1);
					end
				end
			end
			SRPD_SELF: begin
				// Device refreshes itself, so no refresh is owed here
				next_st.pend        = 1'b0;
				next_st.pins.cke    = 1'b0;
				next_st.pins.clk_en = 1'b0;
				if (!sr_req) begin
					next_st.fsm         = SRPD_CLK_RUN;
					next_st.pins.clk_en = 1'b1;
				end
			end
			SRPD_CLK_RUN: begin
				next_st.fsm      = SRPD_BURST;
				next_st.pins.cke = 1'b1;
				next_st.timer    = 16'(XSR_CYC);
				next_st.cnt      = 13'(BURST_REFS);
				next_st.to_self  = 1'b0;
			end
			SRPD_PD: begin
				next_st.pins.cke = 1'b0;
				// Pending refresh forces an exit, bounding the stay
				if (!pd_req || st.pend) begin
					next_st.fsm      = SRPD_IDLE;
					next_st.pins.cke = 1'b1;
					next_st.timer    = 16'(PDE_CYC);
				end
			end
		endcase
		if (st.fsm == SRPD_SELF) begin
			next_st.pend = 1'b0;
		end else if (st.refi == '0) begin
			next_st.pend = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st             <= '0;
			st.fsm         <= SRPD_IDLE;
			st.pins.clk_en <= 1'b1;
			st.pins.cke    <= 1'b1;
			st.pins.rcw    <= `SRPD_CMD_NOP;
			st.refi        <= 16'(REFI_CYC - 1);
		end else begin
			st <= next_st;
		end
	end

	// Helper counters read only by the checks below
	logic        cmd_on;
	logic [15:0] gap;
	logic [2:0]  last_cmd;
	logic [15:0] low_run;
	logic [15:0] since_sx;
	assign cmd_on = sd_cke && !sd_cs_n && ({sd_ras_n, sd_cas_n, sd_we_n}
		!= `SRPD_CMD_NOP);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			gap      <= 16'hFFFF;
			last_cmd <= `SRPD_CMD_NOP;
			low_run  <= '0;
			since_sx <= 16'hFFFF;
		end else begin
			if (cmd_on) begin
				gap      <= 16'h0001;
				last_cmd <= {sd_ras_n, sd_cas_n, sd_we_n};
			end else if (gap != 16'hFFFF) begin
				gap <= gap + 16'h0001;
			end
			low_run  <= (!sd_cke && !self_active) ? low_run + 16'h0001 : '0;
			if (st.fsm == SRPD_CLK_RUN) begin
				since_sx <= '0;
			end else if (since_sx != 16'hFFFF) begin
				since_sx <= since_sx + 16'h0001;
			end
		end
	end

	sequence aref_cmd_s;
		!sd_cs_n && sd_cke && {sd_ras_n, sd_cas_n, sd_we_n} == `SRPD_CMD_AREF;
	endsequence
	sequence sref_cmd_s;
		!sd_cs_n && !sd_cke && {sd_ras_n, sd_cas_n, sd_we_n} == `SRPD_CMD_AREF;
	endsequence

	aref_cke_a: assert property (@(posedge clock) disable iff (sys_rst)
		aref_cmd_s |-> $past(sd_cke)) else $error("refresh without prior CKE");
	aref_gap_a: assert property (@(posedge clock) disable iff (sys_rst)
		cmd_on && last_cmd == `SRPD_CMD_AREF |-> gap >= 16'(GAP_CYC))
		else $error("command inside refresh cycle time");
	bst_gap_a: assert property (@(posedge clock) disable iff (sys_rst)
		cmd_on && last_cmd == `SRPD_CMD_BST |-> gap >= 16'(CAS_LAT))
		else $error("command before burst stop drained");
	sref_entry_a: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(self_active) |-> sref_cmd_s ##0 $past(sd_cke))
		else $error("self refresh entered without entry command");
	self_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		self_active |-> !sd_cke) else $error("CKE high in self refresh");
	clk_first_a: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(sd_cke) |-> $past(sd_clk_en)) else $error("CKE before clock");
	cke_rise_nop_a: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(sd_cke) |-> {sd_ras_n, sd_cas_n, sd_we_n} == `SRPD_CMD_NOP)
		else $error("CKE raised with a command");
	pd_exit_a: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(sd_cke) |=> !cmd_on) else $error("command right after exit");
	xsr_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
		cmd_on |-> since_sx > 16'(XSR_CYC)) else $error("command inside exit time");
	pd_bound_a: assert property (@(posedge clock) disable iff (sys_rst)
		low_run <= 16'(REFI_CYC + 1)) else $error("power-down held too long");
	cas_legal_a: assert property (@(posedge clock)
		CAS_LAT >= `SRPD_CAS_LAT_MIN && CAS_LAT <= `SRPD_CAS_LAT_MAX)
		else $error("illegal CAS latency");
endmodule

// File: bench/srpd_sdram_model.sv
// Behavioural DRAM command decoder standing at the memory pins.
// Assumes the system clock, with the clock gate used as an enable.
`timescale 1ns/100ps
`include "srpd_consts.svh"
module srpd_sdram_model (
	input wire logic       clock,
	input wire logic       clk_en,
	input wire logic       cke,
	input wire logic       cs_n,
	input wire logic [2:0] rcw,
	input wire logic [1:0] dqm
);
	localparam int XSR = (`SRPD_TXSR_NS * `SRPD_CLK_MHZ + 999) / 1000;
	int         ref_cnt  = 0;
	int         bst_cnt  = 0;
	int         err_cnt  = 0;
	int         quiet    = 0;
	logic       in_self  = 1'b0;
	logic       in_pd    = 1'b0;
	logic       cke_q    = 1'b1;
	logic [1:0] last_dqm = 2'h0;
	logic       is_nop;

	assign is_nop = cs_n || rcw == `SRPD_CMD_NOP;

	// Only edges let through by the gate reach the device
	always @(posedge clock) begin
		if (!clk_en && cke && in_self)
			err_cnt++;
		if (clk_en) begin
			if (in_self) begin
				in_self <= !cke;
				quiet   <= cke ? XSR : 0;
			end else if (in_pd) begin
				in_pd <= !cke;
				quiet <= 1;
				if (cke && !is_nop)
					err_cnt++;
			end else if (quiet > 0) begin
				quiet <= quiet - 1;
				if (!is_nop)
					err_cnt++;
			end else if (!is_nop && rcw == `SRPD_CMD_AREF) begin
				if (!cke)
					in_self <= 1'b1;
				else if (!cke_q)
					err_cnt++;
				else
					ref_cnt++;
			end else if (!is_nop && rcw == `SRPD_CMD_BST) begin
				bst_cnt++;
				last_dqm <= dqm;
			end else if (!is_nop)
				err_cnt++;
			else if (!cke)
				in_pd <= 1'b1;
			cke_q <= cke;
		end
	end
endmodule

// File: bench/srpd_ctrl_bench.sv
// Self-checking bench of the refresh and power-down command issuer.
// Assumes the DRAM model of this folder stands at the memory pins.
`timescale 1ns/100ps
`include "srpd_consts.svh"
module srpd_ctrl_bench
	import srpd_pkg::*;
;
	// Short pre-entry burst keeps the self refresh test brief
	localparam int BR = 4;
	logic        clock      = 1'b0;
	logic        sys_rst    = 1'b1;
	srpd_req_t   req        = '0;
	logic        req_valid  = 1'b0;
	logic        pd_req     = 1'b0;
	logic        sr_req     = 1'b0;
	logic        req_ready;
	logic        sd_clk_en;
	logic        sd_cke;
	logic        sd_cs_n;
	logic        sd_ras_n;
	logic        sd_cas_n;
	logic        sd_we_n;
	logic [1:0]  sd_dqm;
	logic [11:0] sd_addr;
	logic [1:0]  sd_ba;
	logic        self_active;
	logic        pd_active;
	logic        refresh_due;
	int          num_errors = 0;
	int          cmp_count  = 0;
	int          cyc        = 0;
	int          seed       = 60686;
	int          b0;
	int          r0;
	logic [31:0] v;
	srpd_req_t   r;

	srpd_ctrl #(.BURST_REFS(BR)) dut (
		.clock(clock), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .pd_req(pd_req), .sr_req(sr_req),
		.sd_clk_en(sd_clk_en), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n),
		.sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n),
		.sd_addr(sd_addr), .sd_ba(sd_ba), .sd_dqm(sd_dqm),
		.self_active(self_active),
		.pd_active(pd_active), .refresh_due(refresh_due));

	srpd_sdram_model mem (
		.clock(clock), .clk_en(sd_clk_en), .cke(sd_cke), .cs_n(sd_cs_n),
		.rcw({sd_ras_n, sd_cas_n, sd_we_n}), .dqm(sd_dqm));

	initial begin
		forever #50 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge clock);
		#10;
	endtask

	// Holds the request until the edge that takes it
	task send(input srpd_req_t x);
		req <= x;
		req_valid <= 1'b1;
		@(posedge clock);
		while (req_ready !== 1'b1)
			@(posedge clock);
		#10;
	endtask

	task stop_test();
		$display("Compares %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			$display("[ERR] %0t run took too long", $time);
			stop_test();
		end
	end

	initial begin
		tick(8);
		check({sd_clk_en, sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dqm,
			req_ready, self_active, pd_active, refresh_due}, 32'hDC8);
		sys_rst <= 1'b0;
		tick(1);
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			v = $random(seed);
			r.op = srpd_op_t'(v[1:0] % 2'h3);
			r.dqm = v[3:2];
			b0 = mem.bst_cnt;
			send(r);
			req_valid <= 1'b0;
			for (int k = 0; k < 20 && mem.bst_cnt == b0; k++)
				tick(1);
			check(mem.bst_cnt - b0, r.op == SRPD_OP_BST);
			if (r.op == SRPD_OP_BST)
				check(mem.last_dqm, r.dqm);
		end
		$display("test random commands done");
		r0 = mem.ref_cnt;
		sr_req <= 1'b1;
		for (int k = 0; k < 400 && self_active !== 1'b1; k++)
			tick(1);
		tick(2);
		check({self_active, mem.in_self, sd_clk_en, sd_cke}, 32'hC);
		check(mem.ref_cnt - r0 >= BR, 1'b1);
		b0 = mem.bst_cnt;
		r = '{op: SRPD_OP_BST, dqm: 2'h1};
		send(r);
		r.dqm = 2'h2;
		send(r);
		r.dqm = 2'h3;
		req <= r;
		tick(3);
		check(req_ready, 1'b0);
		sr_req <= 1'b0;
		send(r);
		req_valid <= 1'b0;
		for (int k = 0; k < 400 && mem.bst_cnt != b0 + 3; k++)
			tick(1);
		check(mem.bst_cnt - b0, 32'h3);
		check(mem.last_dqm, 2'h3);
		check(mem.ref_cnt - r0 >= 2 * BR, 1'b1);
		$display("test self refresh done");
		pd_req <= 1'b1;
		for (int k = 0; k < 50 && pd_active !== 1'b1; k++)
			tick(1);
		tick(2);
		check({pd_active, sd_cke, mem.in_pd}, 32'h5);
		r0 = mem.ref_cnt;
		// Longer than one refresh interval, so power-down must break
		tick(200);
		check(mem.ref_cnt > r0, 1'b1);
		pd_req <= 1'b0;
		for (int k = 0; k < 50 && pd_active !== 1'b0; k++)
			tick(1);
		tick(2);
		check({pd_active, sd_cke, mem.in_pd}, 32'h2);
		check(mem.err_cnt, 32'h0);
		check({sd_ba, sd_addr}, 32'h0);
		$display("test power down done");
		stop_test();
	end
endmodule
